// File: rcs_sequencer.sv
// Purpose: checks calibration commands, tracks step completion, runs remote erase
// Assumes: bus side delivers decoded commands; measurement side signals done
// Notes: no software registers; status and errors are plain ports
`timescale 1ns/10ps
`include "rcs_defines.svh"
module rcs_sequencer #(
  parameter int QDEPTH = `RCS_QUEUE_DEPTH
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire rcs_pkg::rcs_cmd_e cmd_code,
  input wire rcs_pkg::rcs_mode_e cal_mode,
  input wire logic srq_mask_step,
  input wire logic srq_clear,
  input wire logic meas_ready,
  input wire logic meas_done,
  input wire logic sample_done_raw,
  output logic meas_cmd_valid,
  output rcs_pkg::rcs_cmd_e meas_cmd_code,
  output logic erase_all,
  output logic erase_prompt,
  output logic step_complete,
  output logic srq,
  output logic [7:0] err_num,
  output logic err_valid,
  output logic sample_complete
);
  import rcs_pkg::*;

  initial
  begin
    if (QDEPTH < 2 || (QDEPTH & (QDEPTH - 1)) != 0)
      $error("rcs_sequencer: QDEPTH must be a power of two, at least 2");
  end

  // ==========================================
  // Input queue
  logic [4:0] q_head;
  logic q_ne;
  logic q_ovf;
  logic q_pop;

  rcs_cmd_queue #(.WIDTH(5), .DEPTH(QDEPTH)) u_queue (
    .core_clk(core_clk),
    .nrst(nrst),
    .push(cmd_valid),
    .push_data(cmd_code),
    .pop(q_pop),
    .head_data(q_head),
    .not_empty(q_ne),
    .overflow(q_ovf)
  );

  rcs_cmd_e head_cmd;
  assign head_cmd = rcs_cmd_e'(q_head);

  // ==========================================
  // Validity check against the present mode
  wire m_norm = (cal_mode == RCS_MODE_NORMAL);
  wire m_ad = (cal_mode == RCS_MODE_AD);
  wire m_og = (cal_mode == RCS_MODE_OFS_GAIN);
  wire m_hf = (cal_mode == RCS_MODE_HFAC);
  wire m_ver = (cal_mode == RCS_MODE_VERIFY);
  wire m_sub = m_ad || m_og || m_hf || m_ver;

  // Commands never valid inside any calibration sub-mode
  wire c_blk = (head_cmd == RCS_CMD_B) || (head_cmd == RCS_CMD_D) ||
               (head_cmd == RCS_CMD_P0) || (head_cmd == RCS_CMD_R0) ||
               (head_cmd == RCS_CMD_R16) || (head_cmd == RCS_CMD_R7) ||
               (head_cmd == RCS_CMD_T) || (head_cmd == RCS_CMD_Z0) ||
               (head_cmd == RCS_CMD_STAR);
  // Commands that need calibration enabled at all
  wire c_cal = (head_cmd == RCS_CMD_STORE) || (head_cmd == RCS_CMD_AD) ||
               (head_cmd == RCS_CMD_HFAC) || (head_cmd == RCS_CMD_ERASE) ||
               (head_cmd == RCS_CMD_PROMPT) || (head_cmd == RCS_CMD_VARIN) ||
               (head_cmd == RCS_CMD_P3);
  wire c_disabled = c_blk || c_cal || (head_cmd == RCS_CMD_F) ||
                    (head_cmd == RCS_CMD_G3) || (head_cmd == RCS_CMD_R8) ||
                    (head_cmd == RCS_CMD_S) || (head_cmd == RCS_CMD_QUERY);
  wire c_verr = (head_cmd == RCS_CMD_STORE) || (head_cmd == RCS_CMD_PROMPT) ||
                (head_cmd == RCS_CMD_VARIN);
  wire c_sub52 = c_blk || ((head_cmd == RCS_CMD_R8) && (m_ad || m_hf)) ||
                 ((head_cmd == RCS_CMD_S) && !m_ver);

  logic [7:0] chk_err;
  always_comb
  begin
    chk_err = `RCS_ERR_NONE;
    if (m_norm && c_cal)
      chk_err = `RCS_ERR_NOT_CAL;
    else if (cal_mode == RCS_MODE_CAL_IDLE && c_disabled)
      chk_err = `RCS_ERR_CAL_DISABLED;
    else if (m_sub && c_sub52)
      chk_err = `RCS_ERR_BAD_SUBMODE;
    else if (m_ad && head_cmd == RCS_CMD_VARIN)
      chk_err = `RCS_ERR_AD_VARIN;
    else if (m_ver && c_verr)
      chk_err = `RCS_ERR_VERIFY;
  end

  // ==========================================
  // Sequencer
  rcs_state_e state_reg;
  rcs_state_e state_next;
  wire is_store = (head_cmd == RCS_CMD_STORE);
  wire is_erase = (head_cmd == RCS_CMD_ERASE);
  wire cmd_ok = (chk_err == `RCS_ERR_NONE);
  wire can_take = (state_reg == RCS_ST_IDLE) || (state_reg == RCS_ST_ERASE_PEND);
  wire take = can_take && q_ne && meas_ready;
  // Erase request is held locally; everything else valid goes to the measurement side
  wire fwd = take && cmd_ok && !is_erase;
  // A store refused in the present mode abandons the request instead of erasing
  wire do_erase = take && cmd_ok && (state_reg == RCS_ST_ERASE_PEND) && is_store;

  assign q_pop = take;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      RCS_ST_IDLE:
      begin
        if (take && cmd_ok && is_erase)
          state_next = RCS_ST_ERASE_PEND;
        else if (fwd)
          state_next = RCS_ST_BUSY;
      end
      RCS_ST_ERASE_PEND:
      begin
        // No timer here: the request waits for whatever comes next
        if (do_erase)
          state_next = RCS_ST_ERASING;
        else if (take && cmd_ok && is_erase)
          state_next = RCS_ST_ERASE_PEND;
        else if (fwd)
          state_next = RCS_ST_BUSY;
        else if (take)
          state_next = RCS_ST_IDLE;
      end
      RCS_ST_BUSY, RCS_ST_ERASING:
      begin
        if (meas_done)
          state_next = RCS_ST_IDLE;
      end
      default: state_next = RCS_ST_IDLE;
    endcase
  end

  // ==========================================
  // Next values of the registered outputs
  logic step_next;
  logic srq_next;
  logic sample_next;
  logic err_hit;
  logic [7:0] err_next;
  // A finish and a new forward never meet: forwarding needs the idle or erase-pending state
  assign step_next = fwd ? 1'b0 : (meas_done ? 1'b1 : step_complete);
  // Set wins over the poll clear so that a completion is never lost
  assign srq_next = (meas_done && (state_reg != RCS_ST_IDLE) && srq_mask_step) ? 1'b1 :
                    (srq_clear ? 1'b0 : srq);
  assign sample_next = (m_norm || m_ver) ? sample_done_raw : 1'b0;
  assign err_hit = (take && !cmd_ok) || q_ovf;
  // Overflow outranks a rejection in the same cycle; only one number can stand
  assign err_next = q_ovf ? `RCS_ERR_OVERFLOW : chk_err;

  // ==========================================
  // State register
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      state_reg <= RCS_ST_IDLE;
    else
      state_reg <= state_next;
  end

  // ==========================================
  // Measurement-side strobes
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      meas_cmd_valid <= 1'b0;
      meas_cmd_code <= RCS_CMD_B;
      erase_all <= 1'b0;
      erase_prompt <= 1'b0;
    end
    else
    begin
      meas_cmd_valid <= fwd && !do_erase;
      meas_cmd_code <= head_cmd;
      erase_all <= do_erase;
      erase_prompt <= (state_next == RCS_ST_ERASE_PEND);
    end
  end

  // ==========================================
  // Status toward the bus side
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      step_complete <= 1'b1;
      srq <= 1'b0;
      sample_complete <= 1'b0;
    end
    else
    begin
      step_complete <= step_next;
      srq <= srq_next;
      sample_complete <= sample_next;
    end
  end

  // ==========================================
  // Error reporting
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      err_num <= `RCS_ERR_NONE;
      err_valid <= 1'b0;
    end
    else
    begin
      err_valid <= err_hit;
      if (err_hit)
        err_num <= err_next;
    end
  end
endmodule : rcs_sequencer

// File: rcs_defines.svh
// Functional notes
// - A command invalid in the present mode is rejected with its fixed error number.
// - Variable input in A/D cal gives 56; store, prompt, variable input in verify give 54.
// - Step-complete bit clears whenever a command is passed to the measurement side.
// - Step-complete bit sets again when the measurement side finishes and is ready.
// - With the mask bit enabled, completion raises service request and the poll bit.
// - Erase request followed directly by store erases the whole calibration memory.
// - Any command other than store or another erase request after a pending erase request abandons the erasure.
// - A pending remote erase request never times out; it waits for the next command.
// - Only whole-memory erasure is offered remotely; no selective erasure.
// - Erase request shows the erase prompt on the display, not in the output buffer.
// - Sample-complete output stays inactive in calibration, normal during verification.
// Purpose: constants of the remote calibration command sequencer
// Assumes: error numbers are binary-coded on an 8-bit field
// Notes: command codes are this block's own encoding of the decoded opcode
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

// ==========================================
// Error numbers
`define RCS_ERR_NONE 8'h00
`define RCS_ERR_NOT_CAL 8'h33
`define RCS_ERR_BAD_SUBMODE 8'h34
`define RCS_ERR_VERIFY 8'h36
`define RCS_ERR_AD_VARIN 8'h38
`define RCS_ERR_CAL_DISABLED 8'h3C
`define RCS_ERR_OVERFLOW 8'h3D

// ==========================================
// Queue and timing
`define RCS_QUEUE_DEPTH 8
`define RCS_CLK_MHZ 100
`define RCS_STORE_MAX_S 22
`define RCS_ERASE_MAX_S 3

`endif

// File: rcs_pkg.sv
// Purpose: types of the remote calibration command sequencer
// Assumes: opcodes are decoded before reaching the block
// Notes: none
package rcs_pkg;
  // ==========================================
  // Commands
  typedef enum logic [4:0] {
    RCS_CMD_B = 5'h00, RCS_CMD_STORE = 5'h01, RCS_CMD_AD = 5'h02, RCS_CMD_HFAC = 5'h03,
    RCS_CMD_ERASE = 5'h04, RCS_CMD_D = 5'h05, RCS_CMD_F = 5'h06, RCS_CMD_G0 = 5'h07,
    RCS_CMD_G1 = 5'h08, RCS_CMD_PROMPT = 5'h09, RCS_CMD_G3 = 5'h0A, RCS_CMD_GX = 5'h0B,
    RCS_CMD_N = 5'h0C, RCS_CMD_P0 = 5'h0D, RCS_CMD_P1 = 5'h0E, RCS_CMD_VARIN = 5'h0F,
    RCS_CMD_P3 = 5'h10, RCS_CMD_R0 = 5'h11, RCS_CMD_R16 = 5'h12, RCS_CMD_R7 = 5'h13,
    RCS_CMD_R8 = 5'h14, RCS_CMD_S = 5'h15, RCS_CMD_T = 5'h16, RCS_CMD_W = 5'h17,
    RCS_CMD_X0 = 5'h18, RCS_CMD_Y = 5'h19, RCS_CMD_Z0 = 5'h1A, RCS_CMD_STAR = 5'h1B,
    RCS_CMD_QUERY = 5'h1C
  } rcs_cmd_e;

  // Calibration sub-mode as reported by the measurement side
  typedef enum logic [2:0] {
    RCS_MODE_NORMAL = 3'h0, RCS_MODE_CAL_IDLE = 3'h1, RCS_MODE_AD = 3'h2,
    RCS_MODE_OFS_GAIN = 3'h3, RCS_MODE_HFAC = 3'h4, RCS_MODE_VERIFY = 3'h5
  } rcs_mode_e;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    RCS_ST_IDLE = 4'b0001, RCS_ST_ERASE_PEND = 4'b0010,
    RCS_ST_BUSY = 4'b0100, RCS_ST_ERASING = 4'b1000
  } rcs_state_e;
endpackage : rcs_pkg

// File: rcs_cmd_queue.sv
// Purpose: in-order input queue for commands arriving during a step
// Assumes: single clock, synchronous active-low reset
// Notes: overflow is high one cycle per refused push, so it stays high while pushes into a full queue go on; the arriving command is dropped
`timescale 1ns/10ps
module rcs_cmd_queue #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head_data,
  output logic not_empty,
  output logic overflow
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("rcs_cmd_queue: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire empty = (wr_reg == rd_reg);
  wire do_pop = pop && !empty;
  // Pop frees a slot in the same cycle, so push into a full queue that pops is fine
  wire do_push = push && (!full || do_pop);

  assign head_data = mem[rd_reg[AW-1:0]];
  assign not_empty = !empty;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      overflow <= 1'b0;
    end
    else
    begin
      if (do_push)
        wr_reg <= wr_reg + 1'b1;
      if (do_pop)
        rd_reg <= rd_reg + 1'b1;
      overflow <= push && !do_push;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (do_push)
      mem[wr_reg[AW-1:0]] <= push_data;
  end
endmodule : rcs_cmd_queue

// File: rcs_meas_model.sv
// Purpose: measurement-side stand-in that takes forwarded steps
// Assumes: one step or erase at a time
// Notes: DELAY stands in for seconds-long steps
`timescale 1ns/10ps
module rcs_meas_model #(
  parameter int DELAY = 10
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic meas_cmd_valid,
  input wire logic erase_all,
  output logic meas_ready,
  output logic meas_done
);
  int cnt_reg;
  // ==========================================
  // Busy countdown
  always_ff @(posedge core_clk)
  begin
    meas_done <= 1'b0;
    if (!nrst)
    begin
      cnt_reg <= 0;
      meas_ready <= 1'b1;
    end
    else if (meas_cmd_valid || erase_all)
    begin
      cnt_reg <= DELAY;
      meas_ready <= 1'b0;
    end
    else if (cnt_reg == 1)
    begin
      cnt_reg <= 0;
      meas_done <= 1'b1;
      meas_ready <= 1'b1;
    end
    else if (cnt_reg != 0)
      cnt_reg <= cnt_reg - 1;
  end
endmodule : rcs_meas_model

// File: rcs_chk.sv
// Purpose: port-level checks of the sequencer
// Assumes: single clock, sync active-low reset
// Notes: bound to every sequencer instance
`timescale 1ns/10ps
`include "rcs_defines.svh"
module rcs_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire rcs_pkg::rcs_mode_e cal_mode,
  input wire logic srq_mask_step,
  input wire logic srq_clear,
  input wire logic meas_done,
  input wire logic meas_cmd_valid,
  input wire logic erase_all,
  input wire logic erase_prompt,
  input wire logic step_complete,
  input wire logic srq,
  input wire logic [7:0] err_num,
  input wire logic err_valid,
  input wire logic sample_complete
);
  import rcs_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // Properties
  sequence s_masked_done;
    meas_done && srq_mask_step;
  endsequence
  sequence s_in_cal;
    cal_mode != RCS_MODE_NORMAL && cal_mode != RCS_MODE_VERIFY;
  endsequence
  property p_fwd_clears; meas_cmd_valid |-> !step_complete; endproperty
  property p_done_sets; meas_done |=> step_complete; endproperty
  property p_srq_done; s_masked_done |=> srq && step_complete; endproperty
  property p_srq_holds; srq && !srq_clear |=> srq; endproperty
  property p_erase_src; erase_all |-> $past(erase_prompt) && !meas_cmd_valid; endproperty
  property p_erase_pulse; erase_all |=> !erase_all && !erase_prompt; endproperty
  property p_pend; (erase_prompt && !cmd_valid) [*3] |=> erase_prompt; endproperty
  property p_sample; s_in_cal [*2] |-> !sample_complete; endproperty
  property p_err_code;
    err_valid |-> err_num inside {`RCS_ERR_NOT_CAL, `RCS_ERR_BAD_SUBMODE, `RCS_ERR_VERIFY,
      `RCS_ERR_AD_VARIN, `RCS_ERR_CAL_DISABLED, `RCS_ERR_OVERFLOW};
  endproperty
  a_fwd_clears: assert property (p_fwd_clears) else $error("step bit set at forward");
  a_done_sets: assert property (p_done_sets) else $error("step bit not set");
  a_srq_done: assert property (p_srq_done) else $error("no service request");
  a_srq_holds: assert property (p_srq_holds) else $error("srq dropped");
  a_erase_src: assert property (p_erase_src) else $error("bad erase");
  a_erase_pulse: assert property (p_erase_pulse) else $error("erase too long");
  a_pend: assert property (p_pend) else $error("erase request lost");
  a_sample: assert property (p_sample) else $error("sample active in cal");
  a_err_code: assert property (p_err_code) else $error("bad error number");
endmodule : rcs_chk
bind rcs_sequencer rcs_chk rcs_chk_i (.core_clk, .nrst, .cmd_valid, .cal_mode,
  .srq_mask_step, .srq_clear, .meas_done, .meas_cmd_valid, .erase_all, .erase_prompt,
  .step_complete, .srq, .err_num, .err_valid, .sample_complete);

// File: tb.sv
// Purpose: self-checking bench of the command sequencer
// Assumes: measurement model answers after 10 cycles
// Notes: controller side waits on status bits; erase and sample scenarios also use fixed delays
`timescale 1ns/10ps
module tb;
  import rcs_pkg::*;
  logic core_clk, nrst, cmd_valid, srq_mask_step, srq_clear, sample_done_raw;
  logic meas_ready, meas_done, meas_cmd_valid, erase_all, erase_prompt;
  logic step_complete, srq, err_valid, sample_complete;
  logic [7:0] err_num;
  rcs_cmd_e cmd_code, meas_cmd_code;
  rcs_mode_e cal_mode;
  int miscompares, num_checks, ovf_cnt, ers_cnt, fwd_cnt, i;
  rcs_sequencer rcs_sequencer_i (.core_clk, .nrst, .cmd_valid, .cmd_code, .cal_mode,
    .srq_mask_step, .srq_clear, .meas_ready, .meas_done, .sample_done_raw, .meas_cmd_valid,
    .meas_cmd_code, .erase_all, .erase_prompt, .step_complete, .srq, .err_num, .err_valid,
    .sample_complete);
  rcs_meas_model rcs_meas_model_i (.core_clk, .nrst, .meas_cmd_valid, .erase_all,
    .meas_ready, .meas_done);
  // ==========================================
  // Helpers
  initial
  begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    ovf_cnt += (err_valid === 1'b1 && err_num === 8'h3D);
    ers_cnt += (erase_all === 1'b1);
    fwd_cnt += (meas_cmd_valid === 1'b1);
  end
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input rcs_cmd_e c, input int n);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    repeat (n) @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask : send
  task automatic wait_fwd(input rcs_cmd_e c);
    for (i = 0; i < 20 && meas_cmd_valid !== 1'b1; i++) tick();
    chk(meas_cmd_code, c);
    chk(step_complete, 0);
    for (i = 0; i < 40 && step_complete !== 1'b1; i++) tick();
    chk(step_complete, 1);
  endtask : wait_fwd
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // ==========================================
  // Scenarios
  task automatic t_errors;
    rcs_mode_e m[6] = '{RCS_MODE_NORMAL, RCS_MODE_AD, RCS_MODE_VERIFY, RCS_MODE_VERIFY,
      RCS_MODE_VERIFY, RCS_MODE_AD};
    rcs_cmd_e c[6] = '{RCS_CMD_STORE, RCS_CMD_VARIN, RCS_CMD_STORE, RCS_CMD_PROMPT,
      RCS_CMD_VARIN, RCS_CMD_B};
    logic [7:0] e[6] = '{8'h33, 8'h38, 8'h36, 8'h36, 8'h36, 8'h34};
    foreach (m[k])
    begin
      @(posedge core_clk);
      cal_mode <= m[k];
      send(c[k], 1);
      for (i = 0; i < 20 && err_valid !== 1'b1; i++) tick();
      chk(err_valid, 1);
      chk(err_num, e[k]);
    end
  endtask : t_errors
  task automatic t_step;
    @(posedge core_clk);
    cal_mode <= RCS_MODE_OFS_GAIN;
    srq_mask_step <= 1'b1;
    send(RCS_CMD_STORE, 1);
    wait_fwd(RCS_CMD_STORE);
    chk(srq, 1);
    @(posedge core_clk);
    srq_clear <= 1'b1;
    @(posedge core_clk);
    srq_clear <= 1'b0;
    tick();
    chk(srq, 0);
  endtask : t_step
  task automatic t_erase;
    send(RCS_CMD_ERASE, 1);
    repeat (30) tick();
    chk(erase_prompt, 1);
    send(RCS_CMD_STORE, 1);
    for (i = 0; i < 20 && erase_all !== 1'b1; i++) tick();
    chk(erase_prompt, 0);
    for (i = 0; i < 40 && step_complete !== 1'b1; i++) tick();
    send(RCS_CMD_ERASE, 1);
    repeat (5) tick();
    send(RCS_CMD_G0, 1);
    wait_fwd(RCS_CMD_G0);
    chk(erase_prompt, 0);
    chk(ers_cnt, 1);
  endtask : t_erase
  task automatic t_queue;
    int base;
    base = fwd_cnt;
    send(RCS_CMD_STORE, 12);
    for (i = 0; i < 400 && fwd_cnt - base < 9; i++) tick();
    chk(fwd_cnt - base, 9);
    chk(ovf_cnt, 3);
  endtask : t_queue
  task automatic t_sample;
    @(posedge core_clk);
    sample_done_raw <= 1'b1;
    cal_mode <= RCS_MODE_AD;
    repeat (3) tick();
    chk(sample_complete, 0);
    @(posedge core_clk);
    cal_mode <= RCS_MODE_VERIFY;
    repeat (3) tick();
    chk(sample_complete, 1);
  endtask : t_sample
  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    {nrst, cmd_valid, srq_mask_step, srq_clear, sample_done_raw} = '0;
    {miscompares, num_checks, ovf_cnt, ers_cnt, fwd_cnt} = '0;
    cmd_code = RCS_CMD_B;
    cal_mode = RCS_MODE_NORMAL;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    t_errors();
    t_step();
    t_erase();
    t_queue();
    t_sample();
    complete_run();
  end
  initial
  begin
    #30000;
    miscompares++;
    complete_run();
  end
endmodule : tb
